// ==== inc/nacc_regs.svh ====
`ifndef NACC_REGS_SVH
`define NACC_REGS_SVH

// reset values of the datapath state
`define NACC_ACC_RESET    4'h0
`define NACC_AUX_RESET    4'h0
`define NACC_CARRY_RESET  1'b0

// field positions of the program-memory byte
`define NACC_ROM_HI_MSB   7
`define NACC_ROM_HI_LSB   4
`define NACC_ROM_LO_MSB   3
`define NACC_ROM_LO_LSB   0

// system clock is the main clock divided by four
`define NACC_SYS_DIV      2'h3

`endif

// ==== inc/nacc_pkg.sv ====
`default_nettype none
package nacc_pkg;

  // operation codes presented to the datapath on a system-clock step
  typedef enum logic [3:0] {
    NACC_OP_NOP      = 4'h0,
    NACC_OP_ADD      = 4'h1,  // acc + mem, carry flag untouched
    NACC_OP_ADDC     = 4'h2,  // acc + mem + carry, carry flag latched
    NACC_OP_ACC2AUX  = 4'h3,
    NACC_OP_AUX2ACC  = 4'h4,
    NACC_OP_ROMTBL   = 4'h5,  // rom_table_read_op
    NACC_OP_SETC     = 4'h6,  // set_carry_op
    NACC_OP_CLRC     = 4'h7,  // clear_carry_op
    NACC_OP_TESTC    = 4'h8,  // test_carry_op
    NACC_OP_LDMEM    = 4'h9,
    NACC_OP_STMEM    = 4'ha,
    NACC_OP_PORTIN   = 4'hb,
    NACC_OP_PORTOUT  = 4'hc,
    NACC_OP_PAIRLD   = 4'hd   // load pair from an 8-bit value
  } nacc_op_t;

  // step sequencer state
  typedef enum logic [1:0] {
    NACC_ST_IDLE = 2'b01,
    NACC_ST_EXEC = 2'b10
  } nacc_state_t;

endpackage
`default_nettype wire

// ==== design/nacc_datapath.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nacc_regs.svh"

module nacc_datapath (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [3:0] op_code,
  input  wire logic       op_valid,
  input  wire logic [3:0] mem_rdata,
  input  wire logic [7:0] rom_byte,
  input  wire logic [7:0] pair_wdata,
  input  wire logic [3:0] port_pins_in,
  output logic      [3:0] acc_out,
  output logic      [3:0] aux_out,
  output logic      [7:0] pair_out,
  output logic            carry_flag,
  output logic      [3:0] mem_wdata,
  output logic            mem_we,
  output logic      [3:0] port_pins_out,
  output logic            port_out_we,
  output logic            skip_next,
  output logic            sys_step,
  output logic            busy
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: port pins come from outside the clock domain

  logic [3:0] pin_meta_q;   // first stage, read only by second stage
  logic [3:0] pin_sync_q;   // second stage, safe to use
  logic [3:0] pin_meta_d;
  logic [3:0] pin_sync_d;

  // next values of the synchroniser
  always_comb begin
    pin_meta_d = port_pins_in;
    pin_sync_d = pin_meta_q;
  end

  // register the synchroniser stages
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end else begin
      pin_meta_q <= pin_meta_d;
      pin_sync_q <= pin_sync_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divide by four: the datapath only steps on this one-cycle enable

  logic [1:0] div_q;
  logic [1:0] div_d;
  logic       step_q;   // high one cycle in four
  logic       step_d;

  // next divider count and enable
  always_comb begin
    div_d  = (div_q == `NACC_SYS_DIV) ? 2'h0 : div_q + 2'h1;
    step_d = (div_q == `NACC_SYS_DIV);
  end

  // register the divider
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      div_q  <= 2'h0;
      step_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      step_q <= step_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: an op is held until the next step enable executes it

  nacc_pkg::nacc_state_t state_q;
  nacc_pkg::nacc_state_t state_d;
  logic [3:0]            op_q;      // captured opcode
  logic [3:0]            op_d;

  // next sequencer state; new ops are ignored while one is pending
  always_comb begin
    state_d = state_q;
    op_d    = op_q;
    case (state_q)
      nacc_pkg::NACC_ST_IDLE: begin
        if (op_valid) begin
          op_d    = op_code;
          state_d = nacc_pkg::NACC_ST_EXEC;
        end
      end
      nacc_pkg::NACC_ST_EXEC: begin
        if (step_q) begin
          state_d = nacc_pkg::NACC_ST_IDLE;
        end
      end
      default: begin
        state_d = nacc_pkg::NACC_ST_IDLE;
      end
    endcase
  end

  // register the sequencer
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= nacc_pkg::NACC_ST_IDLE;
      op_q    <= 4'h0;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
    end
  end

  logic exec;   // the cycle in which the pending op takes effect
  assign exec = (state_q == nacc_pkg::NACC_ST_EXEC) && step_q;

  ////////////////////////////////////////////////////////////////////////////
  // register pair, carry flag and side-output state, declared ahead of the adder that reads it

  logic [3:0] acc_q;
  logic [3:0] acc_d;
  logic [3:0] aux_q;
  logic [3:0] aux_d;
  logic       carry_flag_q;
  logic       carry_flag_d;
  logic [3:0] mem_wdata_q;
  logic [3:0] mem_wdata_d;
  logic       mem_we_q;
  logic       mem_we_d;
  logic [3:0] port_q;
  logic [3:0] port_d;
  logic       port_we_q;
  logic       port_we_d;
  logic       skip_q;
  logic       skip_d;

  ////////////////////////////////////////////////////////////////////////////
  // adder: all four bits summed at once, carry-out is a plain wire

  logic       carry_in;
  logic [4:0] sum_wide;
  logic       alu_carry_out;   // never stored except by the add-with-carry op
  logic [3:0] alu_sum;

  // carry-in only joins the sum for the add-with-carry form
  always_comb begin
    carry_in      = (op_q == nacc_pkg::NACC_OP_ADDC) ? carry_flag_q : 1'b0;
    sum_wide      = {1'b0, acc_q} + {1'b0, mem_rdata} + {4'h0, carry_in};
    alu_sum       = sum_wide[3:0];
    alu_carry_out = sum_wide[4];
  end

  ////////////////////////////////////////////////////////////////////////////
  // register pair, carry flag and side outputs

  // next datapath state; strobes are one cycle wide
  always_comb begin
    acc_d        = acc_q;
    aux_d        = aux_q;
    carry_flag_d = carry_flag_q;
    mem_wdata_d  = mem_wdata_q;
    mem_we_d     = 1'b0;
    port_d       = port_q;
    port_we_d    = 1'b0;
    skip_d       = skip_q;
    if (exec) begin
      skip_d = 1'b0;
      case (op_q)
        nacc_pkg::NACC_OP_ADD: begin
          acc_d = alu_sum;
        end
        nacc_pkg::NACC_OP_ADDC: begin
          acc_d        = alu_sum;
          carry_flag_d = alu_carry_out;
        end
        nacc_pkg::NACC_OP_ACC2AUX: begin
          aux_d = acc_q;
        end
        nacc_pkg::NACC_OP_AUX2ACC: begin
          acc_d = aux_q;
        end
        nacc_pkg::NACC_OP_ROMTBL: begin
          aux_d = rom_byte[`NACC_ROM_HI_MSB:`NACC_ROM_HI_LSB];
          acc_d = rom_byte[`NACC_ROM_LO_MSB:`NACC_ROM_LO_LSB];
        end
        nacc_pkg::NACC_OP_SETC: begin
          carry_flag_d = 1'b1;
        end
        nacc_pkg::NACC_OP_CLRC: begin
          carry_flag_d = 1'b0;
        end
        nacc_pkg::NACC_OP_TESTC: begin
          skip_d = carry_flag_q;
        end
        nacc_pkg::NACC_OP_LDMEM: begin
          acc_d = mem_rdata;
        end
        nacc_pkg::NACC_OP_STMEM: begin
          mem_wdata_d = acc_q;
          mem_we_d    = 1'b1;
        end
        nacc_pkg::NACC_OP_PORTIN: begin
          acc_d = pin_sync_q;
        end
        nacc_pkg::NACC_OP_PORTOUT: begin
          port_d    = acc_q;
          port_we_d = 1'b1;
        end
        nacc_pkg::NACC_OP_PAIRLD: begin
          aux_d = pair_wdata[7:4];
          acc_d = pair_wdata[3:0];
        end
        default: begin
          acc_d = acc_q;   // nop and unused codes leave state alone except skip, cleared above
        end
      endcase
    end
  end

  // register the datapath; the auxiliary register is its own flop set
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      acc_q        <= `NACC_ACC_RESET;
      aux_q        <= `NACC_AUX_RESET;
      carry_flag_q <= `NACC_CARRY_RESET;
      mem_wdata_q  <= 4'h0;
      mem_we_q     <= 1'b0;
      port_q       <= 4'h0;
      port_we_q    <= 1'b0;
      skip_q       <= 1'b0;
    end else begin
      acc_q        <= acc_d;
      aux_q        <= aux_d;
      carry_flag_q <= carry_flag_d;
      mem_wdata_q  <= mem_wdata_d;
      mem_we_q     <= mem_we_d;
      port_q       <= port_d;
      port_we_q    <= port_we_d;
      skip_q       <= skip_d;
    end
  end

  // outputs straight from flops
  assign acc_out       = acc_q;
  assign aux_out       = aux_q;
  assign pair_out      = {aux_q, acc_q};
  assign carry_flag    = carry_flag_q;
  assign mem_wdata     = mem_wdata_q;
  assign mem_we        = mem_we_q;
  assign port_pins_out = port_q;
  assign port_out_we   = port_we_q;
  assign skip_next     = skip_q;
  assign sys_step      = step_q;
  assign busy          = state_q[1];   // exec bit of the one-hot state, no gate after the flop

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_addc_carry_latch: assert property (@(posedge core_clk) disable iff (reset)
    exec && op_q == nacc_pkg::NACC_OP_ADDC |=> carry_flag_q == $past(alu_carry_out))
    else $error("carry flag did not latch adder carry-out");

  chk_add_keeps_carry: assert property (@(posedge core_clk) disable iff (reset)
    exec && op_q == nacc_pkg::NACC_OP_ADD |=> $stable(carry_flag_q))
    else $error("plain add changed the carry flag");

  chk_sum_parallel: assert property (@(posedge core_clk) disable iff (reset)
    exec && op_q == nacc_pkg::NACC_OP_ADDC
    |=> {carry_flag_q, acc_q} == $past({1'b0, acc_q}) + $past({1'b0, mem_rdata}) + $past({4'h0, carry_flag_q}))
    else $error("add with carry gave wrong result");

  chk_set_carry_one: assert property (@(posedge core_clk) disable iff (reset)
    exec && op_q == nacc_pkg::NACC_OP_SETC |=> carry_flag_q)
    else $error("set carry did not give one");

  chk_clear_carry_zero: assert property (@(posedge core_clk) disable iff (reset)
    exec && op_q == nacc_pkg::NACC_OP_CLRC |=> !carry_flag_q)
    else $error("clear carry did not give zero");

  chk_rom_split: assert property (@(posedge core_clk) disable iff (reset)
    exec && op_q == nacc_pkg::NACC_OP_ROMTBL |=> pair_out == $past(rom_byte))
    else $error("rom byte split wrong");

  chk_test_skip: assert property (@(posedge core_clk) disable iff (reset)
    exec && op_q == nacc_pkg::NACC_OP_TESTC |=> skip_next == $past(carry_flag_q))
    else $error("skip does not follow carry flag");

  chk_aux_to_acc: assert property (@(posedge core_clk) disable iff (reset)
    exec && op_q == nacc_pkg::NACC_OP_AUX2ACC |=> acc_q == $past(aux_q) && $stable(aux_q))
    else $error("aux to acc transfer wrong");

  chk_exec_spacing: assert property (@(posedge core_clk) disable iff (reset)
    exec |=> !step_q [*3])
    else $error("step enable faster than one in four");

endmodule
`default_nettype wire

// ==== verification/nacc_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// data memory cell and program memory byte seen by the datapath
module nacc_mem_model (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       mem_we,
  input  wire logic [3:0] mem_wdata,
  input  wire logic       preset_we,
  input  wire logic [3:0] preset_val,
  input  wire logic [7:0] rom_val,
  output logic      [3:0] mem_rdata,
  output logic      [7:0] rom_byte
);
  logic [3:0] cell_q;  // one addressed nibble is enough for the datapath
  ////////////////////////////////////////////////////////////////////////
  // store wins over preset so a store is never silently lost
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cell_q <= 4'h0;
    end else if (mem_we) begin
      cell_q <= mem_wdata;
    end else if (preset_we) begin
      cell_q <= preset_val;
    end
  end
  assign mem_rdata = cell_q;
  assign rom_byte  = rom_val;
endmodule
`default_nettype wire

// ==== verification/nacc_datapath_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module nacc_datapath_tb;
  logic        core_clk = 1'b0, reset = 1'b1, op_valid = 1'b0, preset_we = 1'b0;
  logic [3:0]  op_code = 4'h0, port_pins_in = 4'h0, preset_val = 4'h0;
  logic [7:0]  rom_val = 8'h00, pair_wdata = 8'h00, seed = 8'h59;
  logic [3:0]  mem_rdata, acc_out, aux_out, mem_wdata, port_pins_out;
  logic [7:0]  rom_byte, pair_out;
  logic        carry_flag, mem_we, port_out_we, skip_next, sys_step, busy;
  logic [3:0]  acc_m, aux_m, mem_m, po_m, wd_m, pins_m;  // expected state
  logic        c_m, skip_m, busy_p = 1'b0;
  logic [19:0] exp_q[$];  // notes of expected results
  logic [19:0] note;      // oldest note, taken when a result shows
  int          err_total = 0, n_tests = 0;
  always #50 core_clk = ~core_clk;
  nacc_datapath i_dut (.core_clk(core_clk), .reset(reset), .op_code(op_code), .op_valid(op_valid),
    .mem_rdata(mem_rdata), .rom_byte(rom_byte), .pair_wdata(pair_wdata), .port_pins_in(port_pins_in),
    .acc_out(acc_out), .aux_out(aux_out), .pair_out(pair_out), .carry_flag(carry_flag),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .port_pins_out(port_pins_out), .port_out_we(port_out_we),
    .skip_next(skip_next), .sys_step(sys_step), .busy(busy));
  nacc_mem_model i_mem (.core_clk(core_clk), .reset(reset), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .preset_we(preset_we), .preset_val(preset_val), .rom_val(rom_val), .mem_rdata(mem_rdata),
    .rom_byte(rom_byte));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reset, zero outputs, then sys_step on every fourth edge
  task automatic do_reset(input int cycles);
    @(posedge core_clk);
    #1 reset = 1'b1;
    // a cancelled op must leave no note, or the monitor sees busy fall and compares it
    {acc_m, aux_m, mem_m, po_m, wd_m, c_m, skip_m} = '0;
    exp_q.delete();
    repeat (cycles) @(posedge core_clk);
    #1 check({pair_out, carry_flag, skip_next, port_pins_out, mem_wdata, mem_we, port_out_we}, 20'h0);
    check({aux_out, sys_step, busy}, 20'h0);
    reset = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      @(posedge core_clk);
      #1 check(sys_step, (i % 4) == 0);
    end
    $display("test reset done");
  endtask
  // offer one op, note its expected result
  task automatic do_op(input nacc_pkg::nacc_op_t op);
    logic [4:0] sum;
    int n;
    logic we_m, pwe_m;
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 20) begin
      err_total++;
      end_sim();
    end
    seed = lfsr(seed);
    op_code = op;
    op_valid = 1'b1;
    rom_val = {seed[3:0], seed[7:4]};
    pair_wdata = seed ^ 8'h5a;
    // a store pulse still high at the take edge wins in the memory, so no preset then
    preset_we = seed[0] & ~mem_we;
    preset_val = seed[7:4];
    if (preset_we) mem_m = seed[7:4];
    pins_m = port_pins_in;
    // pins move only when not read: the synchroniser needs them steady
    if (op != nacc_pkg::NACC_OP_PORTIN) port_pins_in = seed[6:3];
    skip_m = 1'b0;
    we_m = (op == nacc_pkg::NACC_OP_STMEM);
    pwe_m = (op == nacc_pkg::NACC_OP_PORTOUT);
    sum = {1'b0, acc_m} + {1'b0, mem_m} + {4'h0, c_m};
    case (op)
      nacc_pkg::NACC_OP_ADD:     acc_m = acc_m + mem_m;
      nacc_pkg::NACC_OP_ADDC:    {c_m, acc_m} = sum;
      nacc_pkg::NACC_OP_ACC2AUX: aux_m = acc_m;
      nacc_pkg::NACC_OP_AUX2ACC: acc_m = aux_m;
      nacc_pkg::NACC_OP_ROMTBL:  {aux_m, acc_m} = rom_val;
      nacc_pkg::NACC_OP_SETC:    c_m = 1'b1;
      nacc_pkg::NACC_OP_CLRC:    c_m = 1'b0;
      nacc_pkg::NACC_OP_TESTC:   skip_m = c_m;
      nacc_pkg::NACC_OP_LDMEM:   acc_m = mem_m;
      nacc_pkg::NACC_OP_STMEM:   {mem_m, wd_m} = {acc_m, acc_m};
      nacc_pkg::NACC_OP_PORTIN:  acc_m = pins_m;
      nacc_pkg::NACC_OP_PORTOUT: po_m = acc_m;
      nacc_pkg::NACC_OP_PAIRLD:  {aux_m, acc_m} = pair_wdata;
      default: ;
    endcase
    exp_q.push_back({aux_m, acc_m, c_m, skip_m, po_m, wd_m, we_m, pwe_m});
    @(posedge core_clk);
    #1 op_valid = 1'b0;
    preset_we = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // result shows at the edge where busy falls
  always @(negedge core_clk) begin
    if (busy_p === 1'b1 && busy === 1'b0 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check({pair_out, carry_flag, skip_next, port_pins_out, mem_wdata, mem_we, port_out_we}, note);
      check({aux_out, acc_out}, note[19:12]);
    end
    busy_p = busy;
  end
  initial begin
    do_reset(12);
    // every op once, carry set first, though the sweep clears it again before its test
    do_op(nacc_pkg::NACC_OP_SETC);
    for (int k = 0; k < 14; k++) do_op(nacc_pkg::nacc_op_t'(k));
    // the sweep clears carry before its test, so test once more with carry set
    do_op(nacc_pkg::NACC_OP_SETC);
    do_op(nacc_pkg::NACC_OP_TESTC);
    $display("test all_ops done");
    for (int k = 0; k < 300; k++) begin
      seed = lfsr(seed);
      do_op(nacc_pkg::nacc_op_t'(seed % 14));
    end
    $display("test random done");
    do_reset(2);
    do_op(nacc_pkg::NACC_OP_ADDC);
    do_op(nacc_pkg::NACC_OP_LDMEM);
    repeat (8) @(posedge core_clk);
    check(20'(exp_q.size()), 20'h0);
    $display("test after_reset done");
    end_sim();
  end
endmodule
`default_nettype wire
